// *** dps_pkg.sv ***
// Shared constants of the dual-port shared memory and semaphore unit
package dps_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int RAM_DEPTH = 256;
	localparam int SEM_COUNT = 6;
	localparam int SYNC_W = 6 + 2 * DATA_W;
	// Register index held in the three lowest address bits
	localparam logic [2:0] REG_IRQ_STATUS = 3'h0;
	localparam logic [2:0] REG_IRQ_CONTROL = 3'h1;
	localparam logic [2:0] REG_SEM_FIRST = 3'h2;
	// Bit positions inside semaphore and interrupt registers
	localparam int SEM_FLAG_BIT = 7;
	localparam int SEM_OWN_BIT = 6;
	localparam int IRQ_FLAG_BIT = 7;
	localparam int IRQ_EN_BIT = 6;
	// Values after reset
	localparam logic [SEM_COUNT-1:0] SEM_FLAG_RESET = 6'h3F;
	localparam logic [SEM_COUNT-1:0] SEM_OWN_A_RESET = 6'h3D;
	localparam logic IRQ_BIT_RESET = 1'b0;
	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	// Port front end states
	typedef enum logic [2:0] {
		FE_IDLE = 3'b001,
		FE_READ = 3'b010,
		FE_WRITE = 3'b100
	} dps_fe_state_type;
endpackage

// *** dps_port_if.sv ***
// Access requests from a port front end to the shared core
interface dps_port_if;
	import dps_pkg::*;
	logic req_rd;
	logic req_wr;
	logic reg_sel;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport fe (output req_rd, output req_wr, output reg_sel, output addr, output wdata,
		input rdata);
	modport core (input req_rd, input req_wr, input reg_sel, input addr, input wdata,
		output rdata);
endinterface

// *** dps_port_fe.sv ***
// Pin front end of one processor port: synchronisers, address latch, access sequencing
module dps_port_fe
	import dps_pkg::*;
#(
	parameter bit SEPARATE_ADDR = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bus_clock,
	input wire logic select_n,
	input wire logic reg_space_sel,
	input wire logic addr_strobe,
	input wire logic read_write,
	input wire logic mode_normal,
	input wire logic [DATA_W-1:0] addr_lines,
	input wire logic [DATA_W-1:0] data_lines_i,
	output logic [DATA_W-1:0] data_lines_o,
	output logic data_lines_oe,
	dps_port_if.fe acc
);
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic e_prev_q;
	logic as_prev_q;
	logic rd_wait_q;
	logic [ADDR_W-1:0] latch_q;
	dps_fe_state_type state_q;
	logic e_s, cs_n_s, rs_s, as_s, rw_s, mode_s;
	logic [DATA_W-1:0] addr_s, data_s, addr_src;
	logic e_rise, e_fall, as_fall;

	//////////////////////////////////////////////////////////////////////////
	// Two flip-flops on every pin before use
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {bus_clock, select_n, reg_space_sel, addr_strobe, read_write,
				mode_normal, addr_lines, data_lines_i};
			sync_q <= meta_q;
		end
	end

	assign {e_s, cs_n_s, rs_s, as_s, rw_s, mode_s, addr_s, data_s} = sync_q;
	assign addr_src = SEPARATE_ADDR ? addr_s : data_s;
	assign e_rise = e_s & ~e_prev_q;
	assign e_fall = ~e_s & e_prev_q;
	assign as_fall = ~as_s & as_prev_q;

	//////////////////////////////////////////////////////////////////////////
	// Edge history and address latch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			e_prev_q <= 1'b0;
			as_prev_q <= 1'b0;
			latch_q <= BYTE_RESET;
		end else begin
			e_prev_q <= e_s;
			as_prev_q <= as_s;
			if (as_fall) begin
				latch_q <= addr_src; // R6
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Access sequencing within the bus clock high phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= FE_IDLE;
			acc.req_rd <= 1'b0;
			acc.req_wr <= 1'b0;
			acc.reg_sel <= 1'b0;
			acc.addr <= BYTE_RESET;
			acc.wdata <= BYTE_RESET;
			rd_wait_q <= 1'b0;
		end else begin
			acc.req_rd <= 1'b0;
			acc.req_wr <= 1'b0;
			rd_wait_q <= acc.req_rd;
			case (state_q)
				FE_IDLE: begin
					if (e_rise && !cs_n_s && mode_s) begin // R2 R5 R9 R25
						acc.reg_sel <= rs_s; // R3
						acc.addr <= as_s ? addr_src : latch_q; // R6 R8
						if (rw_s) begin // R10
							acc.req_rd <= 1'b1;
							state_q <= FE_READ;
						end else begin
							state_q <= FE_WRITE;
						end
					end
				end
				FE_READ: begin
					if (e_fall || cs_n_s) begin
						state_q <= FE_IDLE;
					end
				end
				FE_WRITE: begin
					if (cs_n_s) begin // R2
						state_q <= FE_IDLE;
					end else if (e_fall) begin
						acc.req_wr <= 1'b1; // R9 R10
						state_q <= FE_IDLE;
					end else begin
						acc.wdata <= data_s; // R7
					end
				end
				default: state_q <= FE_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read data drive, only while selected and bus clock high
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_lines_o <= BYTE_RESET;
			data_lines_oe <= 1'b0;
		end else if (state_q == FE_READ && !e_fall && !cs_n_s && e_s) begin // R2 R7
			if (rd_wait_q) begin
				data_lines_o <= acc.rdata;
				data_lines_oe <= 1'b1;
			end
		end else begin
			data_lines_oe <= 1'b0;
		end
	end
endmodule

// *** dps_shared_memory_unit.sv ***
// Top of the dual-port shared memory with semaphores and cross interrupts
// What this block does
// R1 - 256-byte RAM shared by both ports
// R2 - Deselected port ignores cycles, lines undriven
// R3 - Register select low RAM, high registers
// R4 - Three low address bits pick register
// R5 - Normal operation needs configuration input high
// R6 - Port A address latched on strobe fall
// R7 - Port A lines carry data during clock high
// R8 - Port B strobe high means separate buses
// R9 - Transfers happen in the bus clock high
// R10 - Read/write line high reads, low writes
// R11 - Concurrent different or same reads both succeed
// R12 - Write stored, colliding read undefined
// R13 - Software avoids same-location write collisions
// R14 - Six semaphores: bit7 flag, bit6 owner
// R15 - Semaphores never gate RAM accesses
// R16 - Semaphore write clears flag, ignores data
// R17 - Semaphore read returns flag then sets it
// R18 - Tied read of clear: A zero, B one
// R19 - Reset loads semaphores, clears interrupt bits, not RAM
// R20 - Control write interrupts other port if enabled
// R21 - Owner set on flag rise, complementary views
// R22 - Write acts only with flag and owner one
// R23 - Reset: all flags one, B owns second
// R24 - Control read returns bits, clears own flag
// R25 - Accesses finish within own clock high phase
module dps_shared_memory_unit
	import dps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mode_normal,
	input wire logic port_a_bus_clock,
	input wire logic port_a_select_n,
	input wire logic port_a_reg_space_sel,
	input wire logic port_a_addr_strobe,
	input wire logic port_a_read_write,
	input wire logic [DATA_W-1:0] port_a_muxed_lines_i,
	output logic [DATA_W-1:0] port_a_muxed_lines_o,
	output logic port_a_muxed_lines_oe,
	input wire logic port_a_interrupt_n_i,
	output logic port_a_interrupt_n_o,
	output logic port_a_interrupt_n_oe,
	input wire logic port_b_bus_clock,
	input wire logic port_b_select_n,
	input wire logic port_b_reg_space_sel,
	input wire logic port_b_addr_strobe,
	input wire logic port_b_read_write,
	input wire logic [ADDR_W-1:0] port_b_addr_lines,
	input wire logic [DATA_W-1:0] port_b_data_lines_i,
	output logic [DATA_W-1:0] port_b_data_lines_o,
	output logic port_b_data_lines_oe,
	input wire logic port_b_interrupt_n_i,
	output logic port_b_interrupt_n_o,
	output logic port_b_interrupt_n_oe
);
	dps_port_if pa_if ();
	dps_port_if pb_if ();

	logic [DATA_W-1:0] ram [RAM_DEPTH];
	logic [SEM_COUNT-1:0] sem_q;
	logic [SEM_COUNT-1:0] own_a_q;
	logic en_a_q, flag_a_q, en_b_q, flag_b_q;
	logic [DATA_W-1:0] rdata_a_q, rdata_b_q;
	logic [SEM_COUNT-1:0] a_rd_hit, a_wr_hit, b_rd_hit, b_wr_hit;
	logic [DATA_W-1:0] reg_view_a, reg_view_b;
	logic a_rd_reg, a_wr_reg, b_rd_reg, b_wr_reg;

	//////////////////////////////////////////////////////////////////////////
	// Register decode helpers
	function automatic logic is_sem(input logic [ADDR_W-1:0] addr);
		return addr[2:0] >= REG_SEM_FIRST; // R4
	endfunction

	function automatic logic [2:0] sem_idx(input logic [ADDR_W-1:0] addr);
		return addr[2:0] - REG_SEM_FIRST; // R4
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Port front ends
	dps_port_fe #(
		.SEPARATE_ADDR(1'b0)
	) u_fe_a (
		.clk(clk),
		.rst_n(rst_n),
		.bus_clock(port_a_bus_clock),
		.select_n(port_a_select_n),
		.reg_space_sel(port_a_reg_space_sel),
		.addr_strobe(port_a_addr_strobe),
		.read_write(port_a_read_write),
		.mode_normal(mode_normal),
		.addr_lines(port_a_muxed_lines_i),
		.data_lines_i(port_a_muxed_lines_i),
		.data_lines_o(port_a_muxed_lines_o),
		.data_lines_oe(port_a_muxed_lines_oe),
		.acc(pa_if.fe)
	);

	dps_port_fe #(
		.SEPARATE_ADDR(1'b1)
	) u_fe_b (
		.clk(clk),
		.rst_n(rst_n),
		.bus_clock(port_b_bus_clock),
		.select_n(port_b_select_n),
		.reg_space_sel(port_b_reg_space_sel),
		.addr_strobe(port_b_addr_strobe),
		.read_write(port_b_read_write),
		.mode_normal(mode_normal),
		.addr_lines(port_b_addr_lines),
		.data_lines_i(port_b_data_lines_i),
		.data_lines_o(port_b_data_lines_o),
		.data_lines_oe(port_b_data_lines_oe),
		.acc(pb_if.fe)
	);

	assign pa_if.rdata = rdata_a_q;
	assign pb_if.rdata = rdata_b_q;

	assign a_rd_reg = pa_if.req_rd && pa_if.reg_sel;
	assign a_wr_reg = pa_if.req_wr && pa_if.reg_sel;
	assign b_rd_reg = pb_if.req_rd && pb_if.reg_sel;
	assign b_wr_reg = pb_if.req_wr && pb_if.reg_sel;

	for (genvar i = 0; i < SEM_COUNT; i++) begin : g_hit
		assign a_rd_hit[i] = a_rd_reg && is_sem(pa_if.addr) && sem_idx(pa_if.addr) == 3'(i);
		assign a_wr_hit[i] = a_wr_reg && is_sem(pa_if.addr) && sem_idx(pa_if.addr) == 3'(i);
		assign b_rd_hit[i] = b_rd_reg && is_sem(pb_if.addr) && sem_idx(pb_if.addr) == 3'(i);
		assign b_wr_hit[i] = b_wr_reg && is_sem(pb_if.addr) && sem_idx(pb_if.addr) == 3'(i);
	end

	//////////////////////////////////////////////////////////////////////////
	// Shared RAM; reset leaves contents alone and semaphores never gate it
	always_ff @(posedge clk) begin
		if (pa_if.req_wr && !pa_if.reg_sel) begin
			ram[pa_if.addr] <= pa_if.wdata; // R1 R11 R15
		end
		if (pb_if.req_wr && !pb_if.reg_sel) begin
			ram[pb_if.addr] <= pb_if.wdata; // R1 R11 R12 R19
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Register read views; B sees a flag that A claims in the same cycle
	always_comb begin
		reg_view_a = BYTE_RESET;
		reg_view_b = BYTE_RESET;
		if (is_sem(pa_if.addr)) begin
			reg_view_a[SEM_FLAG_BIT] = sem_q[sem_idx(pa_if.addr)]; // R14 R17
			reg_view_a[SEM_OWN_BIT] = own_a_q[sem_idx(pa_if.addr)]; // R21
		end else begin
			reg_view_a[IRQ_FLAG_BIT] = flag_a_q;
			reg_view_a[IRQ_EN_BIT] = en_a_q;
		end
		if (is_sem(pb_if.addr)) begin
			reg_view_b[SEM_FLAG_BIT] = sem_q[sem_idx(pb_if.addr)] |
				a_rd_hit[sem_idx(pb_if.addr)]; // R18
			reg_view_b[SEM_OWN_BIT] = ~own_a_q[sem_idx(pb_if.addr)]; // R21
		end else begin
			reg_view_b[IRQ_FLAG_BIT] = flag_b_q;
			reg_view_b[IRQ_EN_BIT] = en_b_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_a_q <= BYTE_RESET;
			rdata_b_q <= BYTE_RESET;
		end else begin
			if (pa_if.req_rd) begin
				rdata_a_q <= pa_if.reg_sel ? reg_view_a : ram[pa_if.addr]; // R3 R11
			end
			if (pb_if.req_rd) begin
				rdata_b_q <= pb_if.reg_sel ? reg_view_b : ram[pb_if.addr]; // R3 R11
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Semaphores: A is served before B when both act in one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sem_q <= SEM_FLAG_RESET; // R19 R23
			own_a_q <= SEM_OWN_A_RESET; // R23
		end else begin
			for (int i = 0; i < SEM_COUNT; i++) begin
				if (a_rd_hit[i] && !sem_q[i]) begin
					sem_q[i] <= 1'b1; // R17
					own_a_q[i] <= 1'b1; // R21
				end else if (b_rd_hit[i] && !sem_q[i]) begin
					sem_q[i] <= 1'b1; // R17
					own_a_q[i] <= 1'b0; // R21
				end else if (a_wr_hit[i] && sem_q[i] && own_a_q[i]) begin
					sem_q[i] <= 1'b0; // R16 R22
				end else if (b_wr_hit[i] && sem_q[i] && !own_a_q[i]) begin
					sem_q[i] <= 1'b0; // R16 R22
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Interrupt registers; a flag set wins over a clearing read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			en_a_q <= IRQ_BIT_RESET; // R19
			flag_a_q <= IRQ_BIT_RESET;
			en_b_q <= IRQ_BIT_RESET;
			flag_b_q <= IRQ_BIT_RESET;
		end else begin
			if (a_wr_reg && pa_if.addr[2:0] == REG_IRQ_STATUS) begin
				en_a_q <= pa_if.wdata[IRQ_EN_BIT];
			end
			if (b_wr_reg && pb_if.addr[2:0] == REG_IRQ_STATUS) begin
				en_b_q <= pb_if.wdata[IRQ_EN_BIT];
			end
			if (b_wr_reg && pb_if.addr[2:0] == REG_IRQ_CONTROL) begin
				flag_a_q <= 1'b1; // R20
			end else if (a_rd_reg && pa_if.addr[2:0] == REG_IRQ_CONTROL) begin
				flag_a_q <= 1'b0; // R24
			end
			if (a_wr_reg && pa_if.addr[2:0] == REG_IRQ_CONTROL) begin
				flag_b_q <= 1'b1; // R20
			end else if (b_rd_reg && pb_if.addr[2:0] == REG_IRQ_CONTROL) begin
				flag_b_q <= 1'b0; // R24
			end
		end
	end

	// Open-drain outputs: level is always low, enable pulls the line
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port_a_interrupt_n_o <= 1'b0;
			port_b_interrupt_n_o <= 1'b0;
			port_a_interrupt_n_oe <= 1'b0;
			port_b_interrupt_n_oe <= 1'b0;
		end else begin
			port_a_interrupt_n_o <= 1'b0;
			port_b_interrupt_n_o <= 1'b0;
			port_a_interrupt_n_oe <= flag_a_q & en_a_q; // R20 R24
			port_b_interrupt_n_oe <= flag_b_q & en_b_q; // R20 R24
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks
	logic [2:0] sidx_a_q;
	logic sem_was_a_q;
	logic [ADDR_W-1:0] ram_addr_a_q;
	logic [DATA_W-1:0] ram_data_a_q;

	always_ff @(posedge clk) begin
		sidx_a_q <= sem_idx(pa_if.addr);
		sem_was_a_q <= sem_q[sem_idx(pa_if.addr)];
		ram_addr_a_q <= pa_if.addr;
		ram_data_a_q <= pa_if.wdata;
	end

	sem_low_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
		(pa_if.req_rd && pa_if.reg_sel && is_sem(pa_if.addr)) |=> (rdata_a_q[5:0] == 6'h00))
		else $error("semaphore read shows nonzero low bits");

	sem_read_sets_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
		(|(a_rd_hit & ~b_wr_hit)) |=>
		(sem_q[sidx_a_q] && rdata_a_q[SEM_FLAG_BIT] == sem_was_a_q))
		else $error("semaphore read did not return then set the flag");

	sem_tie_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
		(|(a_rd_hit & b_rd_hit & ~sem_q)) |=>
		(!rdata_a_q[SEM_FLAG_BIT] && rdata_b_q[SEM_FLAG_BIT] && rdata_a_q[SEM_OWN_BIT]))
		else $error("tied semaphore read not resolved toward port A");

	sem_write_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
		(|(a_wr_hit & sem_q & own_a_q & ~b_rd_hit)) |=> !sem_q[sidx_a_q])
		else $error("owner write did not clear the semaphore");

	sem_write_guard_a: assert property (@(posedge clk) disable iff (!rst_n) // R22
		(|(a_wr_hit & ~(sem_q & own_a_q) & ~b_rd_hit & ~b_wr_hit)) |=>
		(sem_q[sidx_a_q] == sem_was_a_q))
		else $error("non-owner write changed a semaphore");

	sem_reset_state_a: assert property (@(posedge clk) disable iff (!rst_n) // R23
		$rose(rst_n) |-> (sem_q == SEM_FLAG_RESET && own_a_q == SEM_OWN_A_RESET
			&& !flag_a_q && !flag_b_q && !en_a_q && !en_b_q))
		else $error("semaphore or interrupt state wrong after reset");

	irq_raise_a: assert property (@(posedge clk) disable iff (!rst_n) // R20
		(b_wr_reg && pb_if.addr[2:0] == REG_IRQ_CONTROL && en_a_q && !pa_if.req_wr)
		|-> ##2 port_a_interrupt_n_oe)
		else $error("port A interrupt not raised by port B control write");

	irq_read_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R24
		(a_rd_reg && pa_if.addr[2:0] == REG_IRQ_CONTROL && !b_wr_reg) |=> ##1
		(!flag_a_q && !port_a_interrupt_n_oe))
		else $error("control read did not clear port A interrupt");

	ram_write_kept_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
		(pa_if.req_wr && !pa_if.reg_sel && !(pb_if.req_wr && !pb_if.reg_sel))
		|=> (ram[ram_addr_a_q] == ram_data_a_q))
		else $error("RAM write from port A was not stored");
endmodule

// *** dps_bus_model.sv ***
// Two processor bus masters that drive the A and B ports of the shared memory unit
module dps_bus_model
	import dps_pkg::*;
(
	input wire logic clk,
	output logic [1:0] bus_clock,
	output logic [1:0] select_n,
	output logic [1:0] reg_sel,
	output logic [1:0] rw,
	output logic a_strobe,
	output logic [DATA_W-1:0] a_lines,
	output logic [ADDR_W-1:0] b_addr,
	output logic [DATA_W-1:0] b_data,
	output logic b_strobe,
	input wire logic b_muxed
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		bus_clock = 2'b00;
		select_n = 2'b11;
		reg_sel = 2'b00;
		rw = 2'b11;
		a_strobe = 1'b0;
		a_lines = 8'h00;
		b_addr = 8'h00;
		b_data = 8'h00;
		b_strobe = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One bus cycle on side s; released lines show the inverse of their last value
	task automatic cyc(input int s, input logic sel, input logic rs, input logic rd,
		input logic [7:0] addr, input logic [7:0] wd);
		@(negedge clk);
		select_n[s] <= ~sel;
		reg_sel[s] <= rs;
		rw[s] <= rd;
		if (s == 0) begin
			a_lines <= addr;
			a_strobe <= 1'b1;
		end else begin
			b_addr <= addr;
			b_data <= addr;
			b_strobe <= 1'b1;
		end
		repeat (2) @(negedge clk);
		if (s == 0) a_strobe <= 1'b0;
		else if (b_muxed) b_strobe <= 1'b0;
		@(negedge clk);
		if (s == 0) a_lines <= rd ? ~addr : wd;
		else b_data <= rd ? ~b_data : wd;
		bus_clock[s] <= 1'b1;
		repeat (8) @(negedge clk);
		bus_clock[s] <= 1'b0;
		repeat (4) @(negedge clk);
		select_n[s] <= 1'b1;
		if (s == 0) a_lines <= ~a_lines;
		else b_data <= ~b_data;
		repeat (3) @(negedge clk);
	endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the dual-port shared memory and semaphore unit
module testbench
	import dps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int SEM1 = REG_SEM_FIRST;
	localparam int SEM3 = REG_SEM_FIRST + 2;
	localparam int ST = REG_IRQ_STATUS;
	localparam int CT = REG_IRQ_CONTROL;
	logic clk, rst_n, mode_normal, a_strobe;
	logic [1:0] bus_clock, select_n, reg_sel, rw;
	logic [DATA_W-1:0] a_drv, b_data, a_o, b_o, a_wire, b_wire;
	logic [ADDR_W-1:0] b_addr;
	logic b_strobe, b_mux;
	logic a_oe, b_oe, a_irq_o, b_irq_o, a_irq_oe, b_irq_oe, a_irq_n, b_irq_n, a_oe_q, b_oe_q;
	logic [DATA_W-1:0] exp_a[$];
	logic [DATA_W-1:0] exp_b[$];
	int n_fail;
	int checks;

	assign a_wire = (a_oe === 1'b1) ? a_o : a_drv;
	assign b_wire = (b_oe === 1'b1) ? b_o : b_data;
	// Open-drain interrupt lines with pull-up
	assign a_irq_n = (a_irq_oe === 1'b1) ? a_irq_o : 1'b1;
	assign b_irq_n = (b_irq_oe === 1'b1) ? b_irq_o : 1'b1;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	dps_bus_model dps_bus_model_inst (.clk(clk), .bus_clock(bus_clock), .select_n(select_n),
		.reg_sel(reg_sel), .rw(rw), .a_strobe(a_strobe), .a_lines(a_drv), .b_addr(b_addr),
		.b_data(b_data), .b_strobe(b_strobe), .b_muxed(b_mux));

	dps_shared_memory_unit dps_shared_memory_unit_inst (.clk(clk), .rst_n(rst_n),
		.mode_normal(mode_normal), .port_a_bus_clock(bus_clock[0]),
		.port_a_select_n(select_n[0]), .port_a_reg_space_sel(reg_sel[0]),
		.port_a_addr_strobe(a_strobe), .port_a_read_write(rw[0]),
		.port_a_muxed_lines_i(a_wire), .port_a_muxed_lines_o(a_o),
		.port_a_muxed_lines_oe(a_oe), .port_a_interrupt_n_i(a_irq_n),
		.port_a_interrupt_n_o(a_irq_o), .port_a_interrupt_n_oe(a_irq_oe),
		.port_b_bus_clock(bus_clock[1]), .port_b_select_n(select_n[1]),
		.port_b_reg_space_sel(reg_sel[1]), .port_b_addr_strobe(b_strobe),
		.port_b_read_write(rw[1]), .port_b_addr_lines(b_mux ? b_wire : b_addr),
		.port_b_data_lines_i(b_wire), .port_b_data_lines_o(b_o),
		.port_b_data_lines_oe(b_oe), .port_b_interrupt_n_i(b_irq_n),
		.port_b_interrupt_n_o(b_irq_o), .port_b_interrupt_n_oe(b_irq_oe));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: read %h, wanted %h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic e, input logic g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: interrupt line %b, wanted %b", $time, g, e);
		end
	endtask

	// Each rising drive enable is one read answer
	always @(negedge clk) begin
		a_oe_q <= a_oe;
		b_oe_q <= b_oe;
		if (a_oe === 1'b1 && a_oe_q !== 1'b1) begin
			if (exp_a.size() > 0) chk_byte(exp_a.pop_front(), a_o);
			else chk_byte(8'h00, 8'hxx);
		end
		if (b_oe === 1'b1 && b_oe_q !== 1'b1) begin
			if (exp_b.size() > 0) chk_byte(exp_b.pop_front(), b_o);
			else chk_byte(8'h00, 8'hxx);
		end
	end

	function automatic logic [7:0] ra(input int i);
		return {5'($urandom), 3'(i)};
	endfunction

	task automatic rd(input int s, input logic rs, input logic [7:0] a, input logic [7:0] e);
		if (s == 0) exp_a.push_back(e);
		else exp_b.push_back(e);
		dps_bus_model_inst.cyc(s, 1'b1, rs, 1'b1, a, 8'h00);
	endtask

	task automatic wr(input int s, input logic rs, input logic [7:0] a, input logic [7:0] d);
		dps_bus_model_inst.cyc(s, 1'b1, rs, 1'b0, a, d);
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic end_test(input string name);
		int i;
		for (i = 0; i < 40 && exp_a.size() + exp_b.size() > 0; i++) @(negedge clk);
		if (exp_a.size() + exp_b.size() > 0) begin
			n_fail++;
			$display("unexpected at %0t: read answer missing", $time);
			final_report();
		end
		$display("test %s done", name);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		int k;
		logic [7:0] d [4];
		rst_n = 1'b0;
		mode_normal = 1'b1;
		b_mux = 1'b0;
		n_fail = 0;
		checks = 0;
		void'($urandom(66));
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		for (k = 0; k < SEM_COUNT; k++) begin
			rd(0, 1'b1, ra(SEM1 + k), (k == 1) ? 8'h80 : 8'hC0);
			rd(1, 1'b1, ra(SEM1 + k), (k == 1) ? 8'hC0 : 8'h80);
		end
		rd(0, 1'b1, ra(ST), 8'h00);
		chk_pin(1'b1, a_irq_n);
		chk_pin(1'b1, b_irq_n);
		end_test("reset state");
		for (i = 0; i < 4; i++) begin
			d[i] = 8'($urandom);
			wr(i % 2, 1'b0, 8'(i * 85), d[i]);
		end
		for (i = 0; i < 4; i++) rd(1 - i % 2, 1'b0, 8'(i * 85), d[i]);
		fork
			wr(0, 1'b0, 8'h10, d[0]);
			wr(1, 1'b0, 8'h20, d[1]);
		join
		fork
			rd(0, 1'b0, 8'h20, d[1]);
			rd(1, 1'b0, 8'h20, d[1]);
		join
		rd(0, 1'b0, 8'h10, d[0]);
		end_test("shared memory");
		rd(0, 1'b1, ra(SEM1), 8'hC0);
		wr(0, 1'b1, ra(SEM1), 8'($urandom));
		rd(1, 1'b1, ra(SEM1), 8'h00);
		rd(0, 1'b1, ra(SEM1), 8'h80);
		wr(0, 1'b1, ra(SEM1), 8'h00);
		rd(1, 1'b1, ra(SEM1), 8'hC0);
		wr(1, 1'b1, ra(SEM1), 8'hFF);
		rd(1, 1'b1, ra(SEM1), 8'h40);
		rd(0, 1'b1, ra(SEM1), 8'h80);
		wr(0, 1'b0, 8'h33, d[2]);
		rd(0, 1'b0, 8'h33, d[2]);
		wr(0, 1'b1, ra(SEM3), 8'h00);
		fork
			rd(0, 1'b1, ra(SEM3), 8'h40);
			rd(1, 1'b1, ra(SEM3), 8'h80);
		join
		fork
			rd(0, 1'b1, ra(SEM3), 8'hC0);
			rd(1, 1'b1, ra(SEM3), 8'h80);
		join
		end_test("semaphores");
		wr(0, 1'b1, ra(ST), 8'h40);
		wr(1, 1'b1, ra(ST), 8'h40);
		wr(0, 1'b1, ra(CT), 8'($urandom));
		chk_pin(1'b0, b_irq_n);
		chk_pin(1'b1, a_irq_n);
		rd(1, 1'b1, ra(ST), 8'hC0);
		chk_pin(1'b0, b_irq_n);
		rd(1, 1'b1, ra(CT), 8'hC0);
		chk_pin(1'b1, b_irq_n);
		rd(1, 1'b1, ra(ST), 8'h40);
		wr(1, 1'b1, ra(CT), 8'h00);
		chk_pin(1'b0, a_irq_n);
		rd(0, 1'b1, ra(CT), 8'hC0);
		chk_pin(1'b1, a_irq_n);
		wr(1, 1'b1, ra(ST), 8'h00);
		wr(0, 1'b1, ra(CT), 8'h00);
		chk_pin(1'b1, b_irq_n);
		rd(1, 1'b1, ra(ST), 8'h80);
		end_test("interrupts");
		dps_bus_model_inst.cyc(0, 1'b0, 1'b0, 1'b1, 8'h10, 8'h00);
		dps_bus_model_inst.cyc(1, 1'b0, 1'b0, 1'b0, 8'h10, ~d[0]);
		@(negedge clk);
		mode_normal = 1'b0;
		wr(0, 1'b0, 8'h10, ~d[0]);
		dps_bus_model_inst.cyc(1, 1'b1, 1'b0, 1'b1, 8'h10, 8'h00);
		@(negedge clk);
		mode_normal = 1'b1;
		rd(0, 1'b0, 8'h10, d[0]);
		end_test("refused cycles");
		b_mux = 1'b1;
		wr(1, 1'b0, 8'hC3, d[3]);
		rd(1, 1'b0, 8'hC3, d[3]);
		rd(0, 1'b0, 8'hC3, d[3]);
		b_mux = 1'b0;
		end_test("muxed side B");
		wr(1, 1'b1, ra(CT), 8'h00);
		chk_pin(1'b0, a_irq_n);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk_pin(1'b1, a_irq_n);
		rd(0, 1'b1, ra(ST), 8'h00);
		rd(1, 1'b1, ra(SEM1), 8'h80);
		rd(0, 1'b1, ra(SEM3), 8'hC0);
		rd(1, 1'b0, 8'h55, d[1]);
		end_test("second reset");
		final_report();
	end
endmodule
